// file: flash_seq.sv
// Flash program/erase command sequencer with AXI4-Lite registers
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module flash_seq (
    input  logic                clock,
    input  logic                rst,
    input  logic [7:0]          awaddr,
    input  logic                awvalid,
    output logic                awready,
    input  logic [31:0]         wdata,
    input  logic [3:0]          wstrb,
    input  logic                wvalid,
    output logic                wready,
    output logic [1:0]          bresp,
    output logic                bvalid,
    input  logic                bready,
    input  logic [7:0]          araddr,
    input  logic                arvalid,
    output logic                arready,
    output logic [31:0]         rdata,
    output logic [1:0]          rresp,
    output logic                rvalid,
    input  logic                rready,
    output fsq_pkg::array_req_t arr_req,
    input  fsq_pkg::array_rsp_t arr_rsp,
    output logic                blk0_read_invalid
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_CHECK = 6'h02, S_BLANK = 6'h04,
        S_PROG = 6'h08, S_ERASE = 6'h10, S_VFY = 6'h20
    } state_t;

    state_t              state_r;
    state_t              state_nxt;
    logic                cmd_done_r;
    logic                acc_r;
    logic                pv_r;
    logic                ver_r;
    logic                unc_r;
    logic                secured_r;
    logic                blk0_inv_r;
    logic [2:0]          index_r;
    logic [15:0]         param_r [fsq_pkg::SLOTS];
    logic [1:0]          prot_r;
    logic [4:0]          cmden_r;
    logic                bvalid_r;
    logic                rvalid_r;
    logic [1:0]          bresp_r;
    logic [1:0]          rresp_r;
    logic [31:0]         rdata_r;
    fsq_pkg::array_req_t req_r;
    logic                wr_fire;
    logic                rd_fire;
    logic                launch;
    logic                wr_ok;
    logic                rd_ok;
    logic [31:0]         rd_mux;
    logic [7:0]          cmd;
    logic [22:0]         gaddr;
    logic                is_pf;
    logic                is_df;
    logic                known;
    logic [2:0]          cmd_bit;
    logic [2:0]          need_idx;
    logic                chk_acc;
    logic                chk_pv;
    logic                done_in;
    logic                blank_bad;
    logic                vfy_bad;
    logic                end_op;
    logic                sts_wr;

    // AXI4-Lite handshakes
    assign wr_fire = awvalid & wvalid & ~bvalid_r;
    assign awready = wr_fire;
    assign wready  = wr_fire;
    assign rd_fire = arvalid & ~rvalid_r;
    assign arready = ~rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;
    assign arr_req = req_r;
    assign blk0_read_invalid = blk0_inv_r;

    assign wr_ok = awaddr == fsq_pkg::ADDR_STATUS || awaddr == fsq_pkg::ADDR_INDEX
                || awaddr == fsq_pkg::ADDR_PARAM || awaddr == fsq_pkg::ADDR_PROT
                || awaddr == fsq_pkg::ADDR_CMDEN || awaddr == fsq_pkg::ADDR_SEC;
    assign sts_wr = wr_fire & (awaddr == fsq_pkg::ADDR_STATUS) & wstrb[0];
    assign launch = sts_wr & wdata[fsq_pkg::ST_DONE] & cmd_done_r;

    // Parameter decode
    assign cmd     = param_r[0][15:8];
    assign gaddr   = {param_r[0][6:0], param_r[1]};
    assign is_pf   = gaddr[22:16] >= fsq_pkg::PF_BLK_LO;
    assign is_df   = gaddr[22:16] == fsq_pkg::DF_BLK;
    assign known   = cmd >= fsq_pkg::CMD_OTP && cmd <= fsq_pkg::CMD_UNSEC;
    assign cmd_bit = 3'(cmd - fsq_pkg::CMD_OTP);
    assign done_in = arr_rsp.done;
    assign blank_bad = arr_rsp.rdata != fsq_pkg::ERASED;
    assign vfy_bad = arr_rsp.err | (cmd == fsq_pkg::CMD_OTP && arr_rsp.rdata != req_r.data);
    assign end_op  = state_r != S_IDLE && state_nxt == S_IDLE;

    // Launch-time checks
    always_comb
    begin
        need_idx = 3'h7;
        chk_pv   = 1'b0;
        case (cmd)
            fsq_pkg::CMD_OTP:   need_idx = fsq_pkg::IDX_OTP;
            fsq_pkg::CMD_ERALL: need_idx = fsq_pkg::IDX_ERALL;
            fsq_pkg::CMD_ERBLK: need_idx = fsq_pkg::IDX_ERBLK;
            fsq_pkg::CMD_ERSEC: need_idx = fsq_pkg::IDX_ERSEC;
            fsq_pkg::CMD_UNSEC: need_idx = fsq_pkg::IDX_UNSEC;
            default:            need_idx = 3'h7;
        endcase
        chk_acc = !known || !cmden_r[cmd_bit] || index_r != need_idx;
        case (cmd)
            fsq_pkg::CMD_OTP:
                chk_acc = chk_acc | (param_r[1] > fsq_pkg::OTP_MAX);
            fsq_pkg::CMD_ERBLK:
            begin
                chk_acc = chk_acc | !(is_pf | is_df);
                chk_acc = chk_acc | (is_pf & (gaddr[2:0] != 3'h0)) | (is_df & gaddr[0]);
                chk_pv  = (is_pf & prot_r[0]) | (is_df & prot_r[1]);
            end
            fsq_pkg::CMD_ERSEC:
            begin
                chk_acc = chk_acc | !is_pf;
                chk_acc = chk_acc | (gaddr[2:0] != 3'h0);
                chk_pv  = prot_r[0];
            end
            fsq_pkg::CMD_ERALL, fsq_pkg::CMD_UNSEC:
                chk_pv = |prot_r;
            default:
                chk_pv = 1'b0;
        endcase
    end

    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE:
                if (launch)
                    state_nxt = S_CHECK;
            S_CHECK:
                if (chk_acc || chk_pv)
                    state_nxt = S_IDLE;
                else if (cmd == fsq_pkg::CMD_OTP)
                    state_nxt = S_BLANK;
                else
                    state_nxt = S_ERASE;
            S_BLANK:
                if (done_in)
                    state_nxt = blank_bad ? S_IDLE : S_PROG;
            S_PROG, S_ERASE:
                if (done_in)
                    state_nxt = S_VFY;
            S_VFY:
                if (done_in)
                    state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state_r <= S_IDLE;
        else
            state_r <= state_nxt;
    end

    function automatic fsq_pkg::array_op_t op_of(input state_t s, input logic [7:0] c);
        fsq_pkg::array_op_t o;
        o = fsq_pkg::OP_NONE;
        if (s == S_BLANK)
            o = fsq_pkg::OP_READ_OTP;
        else if (s == S_PROG)
            o = fsq_pkg::OP_PROG_OTP;
        else if (s == S_ERASE)
            o = c == fsq_pkg::CMD_ERBLK ? fsq_pkg::OP_ERASE_BLK
              : c == fsq_pkg::CMD_ERSEC ? fsq_pkg::OP_ERASE_SEC : fsq_pkg::OP_ERASE_ALL;
        else if (s == S_VFY)
            o = c == fsq_pkg::CMD_OTP ? fsq_pkg::OP_READ_OTP
              : c == fsq_pkg::CMD_ERBLK ? fsq_pkg::OP_VFY_BLK
              : c == fsq_pkg::CMD_ERSEC ? fsq_pkg::OP_VFY_SEC : fsq_pkg::OP_VFY_ALL;
        return o;
    endfunction

    // Array request, started on each new step
    always_ff @(posedge clock)
    begin
        if (rst)
            req_r <= '0;
        else
        begin
            req_r.start <= state_nxt != state_r && op_of(state_nxt, cmd) != fsq_pkg::OP_NONE;
            req_r.op    <= op_of(state_nxt, cmd);
            req_r.addr  <= cmd == fsq_pkg::CMD_OTP ? {20'h0, param_r[1][2:0]} : gaddr;
            req_r.data  <= {param_r[2], param_r[3], param_r[4], param_r[5]};
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            blk0_inv_r <= 1'b0;
        else
            blk0_inv_r <= state_nxt != S_IDLE && cmd == fsq_pkg::CMD_OTP;
    end

    // Status flags; hardware set wins over software clear
    always_ff @(posedge clock)
    begin
        if (rst)
            cmd_done_r <= 1'b1;
        else if (launch)
            cmd_done_r <= 1'b0;
        else if (end_op)
            cmd_done_r <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            acc_r <= 1'b0;
        else
            acc_r <= (acc_r & ~(sts_wr & wdata[fsq_pkg::ST_ACC]))
                   | (state_r == S_CHECK & chk_acc)
                   | (state_r == S_BLANK & done_in & blank_bad);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            pv_r <= 1'b0;
        else
            pv_r <= (pv_r & ~(sts_wr & wdata[fsq_pkg::ST_PV]))
                  | (state_r == S_CHECK & ~chk_acc & chk_pv);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ver_r <= 1'b0;
            unc_r <= 1'b0;
        end
        else if (launch)
        begin
            ver_r <= 1'b0;
            unc_r <= 1'b0;
        end
        else if (state_r == S_VFY && done_in)
        begin
            ver_r <= vfy_bad;
            unc_r <= arr_rsp.uncorr;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            secured_r <= fsq_pkg::SECURED_RST;
        else if (state_r == S_VFY && done_in && !vfy_bad
                 && (cmd == fsq_pkg::CMD_ERALL || cmd == fsq_pkg::CMD_UNSEC))
            secured_r <= 1'b0;
    end

    // Software registers, frozen while a command runs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            index_r <= 3'h0;
            prot_r  <= fsq_pkg::PROT_RST;
            cmden_r <= fsq_pkg::CMDEN_RST;
        end
        else if (wr_fire && cmd_done_r && wstrb[0])
        begin
            if (awaddr == fsq_pkg::ADDR_INDEX)
                index_r <= wdata[2:0];
            if (awaddr == fsq_pkg::ADDR_PROT)
                prot_r <= wdata[1:0];
            if (awaddr == fsq_pkg::ADDR_CMDEN)
                cmden_r <= wdata[4:0];
        end
    end

    for (genvar i = 0; i < fsq_pkg::SLOTS; i++)
    begin : g_slot
        always_ff @(posedge clock)
        begin
            if (rst)
                param_r[i] <= 16'h0000;
            else if (wr_fire && cmd_done_r && awaddr == fsq_pkg::ADDR_PARAM && index_r == 3'(i))
            begin
                if (wstrb[0])
                    param_r[i][7:0] <= wdata[7:0];
                if (wstrb[1])
                    param_r[i][15:8] <= wdata[15:8];
            end
        end
    end

    // Read data mux
    always_comb
    begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (araddr)
            fsq_pkg::ADDR_STATUS:
                rd_mux = {24'h0, cmd_done_r, 1'b0, acc_r, pv_r, 2'b00, ver_r, unc_r};
            fsq_pkg::ADDR_INDEX:
                rd_mux = {29'h0, index_r};
            fsq_pkg::ADDR_PARAM:
                rd_mux = index_r < 3'(fsq_pkg::SLOTS) ? {16'h0, param_r[index_r]} : 32'h0;
            fsq_pkg::ADDR_PROT:
                rd_mux = {30'h0, prot_r};
            fsq_pkg::ADDR_CMDEN:
                rd_mux = {27'h0, cmden_r};
            fsq_pkg::ADDR_SEC:
                rd_mux = {31'h0, secured_r};
            default:
                rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= fsq_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_DECERR;
        end
        else if (bready)
            bvalid_r <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= fsq_pkg::RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end
        else if (rd_fire)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_DECERR;
            rdata_r  <= rd_mux;
        end
        else if (rready)
            rvalid_r <= 1'b0;
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_launch;
        launch |=> state_r == S_CHECK && !cmd_done_r;
    endproperty
    a_launch: assert property (p_launch) else $error("launch not taken");

    property p_busy;
        state_r != S_IDLE |-> !cmd_done_r;
    endproperty
    a_busy: assert property (p_busy) else $error("flag set while busy");

    property p_check_end;
        state_r == S_CHECK && (chk_acc || chk_pv) |=> cmd_done_r && state_r == S_IDLE && !req_r.start;
    endproperty
    a_check_end: assert property (p_check_end) else $error("failed check ran on");

    property p_otp_idx;
        state_r == S_CHECK && cmd == fsq_pkg::CMD_OTP && index_r != fsq_pkg::IDX_OTP |=> acc_r && cmd_done_r;
    endproperty
    a_otp_idx: assert property (p_otp_idx) else $error("bad index accepted");

    property p_otp_rng;
        state_r == S_CHECK && cmd == fsq_pkg::CMD_OTP && param_r[1] > fsq_pkg::OTP_MAX |=> acc_r;
    endproperty
    a_otp_rng: assert property (p_otp_rng) else $error("bad phrase accepted");

    property p_blank_first;
        $rose(state_r == S_PROG) |-> $past(state_r == S_BLANK) && $past(done_in) && !$past(blank_bad);
    endproperty
    a_blank_first: assert property (p_blank_first) else $error("program without blank check");

    property p_reprog;
        state_r == S_BLANK && done_in && blank_bad |=> acc_r && state_r == S_IDLE ##1 state_r != S_PROG;
    endproperty
    a_reprog: assert property (p_reprog) else $error("programmed phrase rewritten");

    property p_blk0;
        state_r != S_IDLE && cmd == fsq_pkg::CMD_OTP |-> blk0_read_invalid;
    endproperty
    a_blk0: assert property (p_blk0) else $error("block 0 reads not blocked");

    property p_pv_all;
        state_r == S_CHECK && !chk_acc && (cmd == fsq_pkg::CMD_ERALL || cmd == fsq_pkg::CMD_UNSEC)
            && prot_r != 2'h0 |=> pv_r && state_r == S_IDLE;
    endproperty
    a_pv_all: assert property (p_pv_all) else $error("protected erase-all ran");

    property p_vfy;
        state_r == S_VFY && done_in && arr_rsp.err |=> ver_r && cmd_done_r;
    endproperty
    a_vfy: assert property (p_vfy) else $error("verify error lost");

    property p_sec_keep;
        state_r == S_VFY && done_in && vfy_bad |=> $stable(secured_r);
    endproperty
    a_sec_keep: assert property (p_sec_keep) else $error("security changed on failure");

    property p_sec_rel;
        state_r == S_VFY && done_in && !vfy_bad && cmd == fsq_pkg::CMD_ERALL |=> !secured_r;
    endproperty
    a_sec_rel: assert property (p_sec_rel) else $error("security not released");

    property p_sec_align;
        state_r == S_CHECK && cmd == fsq_pkg::CMD_ERSEC && gaddr[2:0] != 3'h0 |=> acc_r;
    endproperty
    a_sec_align: assert property (p_sec_align) else $error("misaligned sector accepted");

    c_otp_ok: cover property (state_r == S_VFY && done_in && !vfy_bad && cmd == fsq_pkg::CMD_OTP);
    c_unsec: cover property (state_r == S_VFY && done_in && !vfy_bad && cmd == fsq_pkg::CMD_UNSEC);
    c_pv: cover property (state_r == S_CHECK && !chk_acc && chk_pv);
endmodule

// file: fsq_pkg.sv
// Shared constants and types for the flash command sequencer
package fsq_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_INDEX  = 8'h04;
    localparam logic [7:0] ADDR_PARAM  = 8'h08;
    localparam logic [7:0] ADDR_PROT   = 8'h0C;
    localparam logic [7:0] ADDR_CMDEN  = 8'h10;
    localparam logic [7:0] ADDR_SEC    = 8'h14;
    // Status bit positions
    localparam int ST_DONE = 7;
    localparam int ST_ACC  = 5;
    localparam int ST_PV   = 4;
    localparam int ST_VER  = 1;
    localparam int ST_UNC  = 0;
    // Command codes
    localparam logic [7:0] CMD_OTP   = 8'h07;
    localparam logic [7:0] CMD_ERALL = 8'h08;
    localparam logic [7:0] CMD_ERBLK = 8'h09;
    localparam logic [7:0] CMD_ERSEC = 8'h0A;
    localparam logic [7:0] CMD_UNSEC = 8'h0B;
    // Parameter index expected at launch
    localparam logic [2:0] IDX_OTP   = 3'h5;
    localparam logic [2:0] IDX_ERALL = 3'h0;
    localparam logic [2:0] IDX_ERBLK = 3'h1;
    localparam logic [2:0] IDX_ERSEC = 3'h1;
    localparam logic [2:0] IDX_UNSEC = 3'h0;
    localparam int         SLOTS     = 6;
    localparam logic [15:0] OTP_MAX  = 16'h0007;
    // Block select codes, global address bits 22:16
    localparam logic [6:0] PF_BLK_LO = 7'h7C;
    localparam logic [6:0] DF_BLK    = 7'h10;
    localparam logic [63:0] ERASED   = 64'hFFFF_FFFF_FFFF_FFFF;
    // Reset values and response codes
    localparam logic [4:0] CMDEN_RST   = 5'h1F;
    localparam logic [1:0] PROT_RST    = 2'h0;
    localparam logic       SECURED_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_ERASE_ALL = 4'h1, OP_ERASE_BLK = 4'h2,
        OP_ERASE_SEC = 4'h3, OP_VFY_ALL = 4'h4, OP_VFY_BLK = 4'h5,
        OP_VFY_SEC = 4'h6, OP_READ_OTP = 4'h7, OP_PROG_OTP = 4'h8
    } array_op_t;
    typedef struct packed {
        logic        start;
        array_op_t   op;
        logic [22:0] addr;
        logic [63:0] data;
    } array_req_t;
    typedef struct packed {
        logic        done;
        logic        err;
        logic        uncorr;
        logic [63:0] rdata;
    } array_rsp_t;
endpackage

// file: tb_flash_seq.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ns
module tb_flash_seq;
    localparam logic [31:0] DONE = 32'(1) << fsq_pkg::ST_DONE;
    localparam logic [31:0] ACC  = DONE | (32'(1) << fsq_pkg::ST_ACC);
    localparam logic [31:0] PV   = DONE | (32'(1) << fsq_pkg::ST_PV);
    localparam logic [31:0] VER  = DONE | (32'(1) << fsq_pkg::ST_VER) | (32'(1) << fsq_pkg::ST_UNC);
    logic                clock   = 1'h0;
    logic                rst     = 1'h1;
    logic [7:0]          awaddr  = 8'h00;
    logic [7:0]          araddr  = 8'h00;
    logic                awvalid = 1'h0;
    logic                wvalid  = 1'h0;
    logic                bready  = 1'h0;
    logic                arvalid = 1'h0;
    logic                rready  = 1'h0;
    logic [31:0]         wdata   = 32'h0;
    logic [3:0]          wstrb   = 4'h0;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic                arready;
    logic                rvalid;
    logic                blk0_read_invalid;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic [1:0]          resp;
    logic [31:0]         rdata;
    fsq_pkg::array_req_t arr_req;
    fsq_pkg::array_rsp_t arr_rsp = '0;
    logic [63:0]         otp [8];
    logic [3:0]          cnt     = 4'h0;
    logic                vf      = 1'h0;
    logic                seen    = 1'h0;
    logic                hit;
    logic                vop;
    logic [63:0]         d1;
    logic [63:0]         d2;
    logic [31:0]         s;
    logic [2:0]          idx [5] = '{fsq_pkg::IDX_OTP, fsq_pkg::IDX_ERALL, fsq_pkg::IDX_ERBLK,
                                     fsq_pkg::IDX_ERSEC, fsq_pkg::IDX_UNSEC};
    int                  seed = 68210;
    int                  starts = 0;
    int                  err_total = 0;
    int                  samples_checked = 0;
    int                  p;

    always #4 clock = ~clock;

    flash_seq uut (.clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .arr_req(arr_req), .arr_rsp(arr_rsp),
        .blk0_read_invalid(blk0_read_invalid));

    // Array stand-in: random step latency, verify failure on demand
    assign hit = (cnt == 4'h1);
    assign vop = arr_req.op == fsq_pkg::OP_VFY_ALL || arr_req.op == fsq_pkg::OP_VFY_BLK
                 || arr_req.op == fsq_pkg::OP_VFY_SEC;
    always @(posedge clock)
    begin
        if (blk0_read_invalid)
            seen <= 1'h1;
        if (arr_req.start)
            starts <= starts + 1;
        arr_rsp.done   <= hit;
        arr_rsp.err    <= hit && vf && vop;
        arr_rsp.uncorr <= hit && vf && vop;
        arr_rsp.rdata  <= hit ? otp[arr_req.addr[2:0]] : ~otp[arr_req.addr[2:0]];
        if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
        else if (arr_req.start)
            cnt <= 4'(3 + $unsigned($random(seed)) % 8);
        if (arr_req.start && arr_req.op == fsq_pkg::OP_PROG_OTP)
            otp[arr_req.addr[2:0]] <= arr_req.data;
    end

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do @(posedge clock); while (!(awready && wready));
        awvalid <= 1'h0;
        wvalid  <= 1'h0;
        do @(posedge clock); while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    // Load slots, launch, poll until complete, then compare status
    task automatic run(input logic [7:0] c, input logic [6:0] b, input logic [15:0] a,
                       input logic [2:0] ix, input logic [31:0] e, input logic [63:0] d = 64'h0,
                       input logic [1:0] pr = 2'h0, input logic [4:0] en = 5'h1F, input logic v = 1'h0,
                       input logic r = 1'h0);
        int          n;
        int          k;
        logic [31:0] s0;
        vf = v;
        wr(fsq_pkg::ADDR_PROT, {30'h0, pr});
        wr(fsq_pkg::ADDR_CMDEN, {27'h0, en});
        for (k = 0; k < 6; k++)
        begin
            wr(fsq_pkg::ADDR_INDEX, 32'(k));
            wr(fsq_pkg::ADDR_PARAM, {16'h0, k == 0 ? {c, 1'h0, b} : k == 1 ? a : d[95 - 16 * k -: 16]});
        end
        wr(fsq_pkg::ADDR_INDEX, {29'h0, ix});
        n = starts;
        seen = 1'h0;
        wr(fsq_pkg::ADDR_STATUS, 32'h0000_00B0);
        rd(fsq_pkg::ADDR_STATUS, s0);
        s = s0;
        for (k = 0; k < 300 && !s[fsq_pkg::ST_DONE]; k++)
            rd(fsq_pkg::ADDR_STATUS, s);
        chk(64'(s), 64'(e));
        chk(64'(starts != n), 64'(r | !(e[fsq_pkg::ST_ACC] | e[fsq_pkg::ST_PV])));
        if (starts != n)
            chk(64'(s0[fsq_pkg::ST_DONE]), 64'h0);
        chk(64'(blk0_read_invalid), 64'h0);
        $display("test code %h addr %h status %h done", c, a, s);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clock);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test;
    end

    initial
    begin
        for (p = 0; p < 8; p++)
            otp[p] = fsq_pkg::ERASED;
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        rd(fsq_pkg::ADDR_STATUS, s);
        chk(64'(s), 64'(DONE));
        chk(64'(resp), 64'(fsq_pkg::RESP_OKAY));
        rd(fsq_pkg::ADDR_SEC, s);
        chk(64'(s), 64'h1);
        rd(fsq_pkg::ADDR_CMDEN, s);
        chk(64'(s), 64'h1F);
        rd(fsq_pkg::ADDR_PROT, s);
        chk(64'(s), 64'h0);
        wr(8'h18, 32'h0);
        chk(64'(resp), 64'(fsq_pkg::RESP_DECERR));
        rd(8'h18, s);
        chk(64'(resp), 64'(fsq_pkg::RESP_DECERR));
        d1 = {$random(seed), $random(seed)};
        d2 = {$random(seed), $random(seed)};
        p = $unsigned($random(seed)) % 8;
        run(fsq_pkg::CMD_OTP, 7'h00, 16'(p), fsq_pkg::IDX_OTP, DONE, d1);
        chk(otp[p], d1);
        chk(64'(seen), 64'h1);
        run(fsq_pkg::CMD_OTP, 7'h00, 16'(p), fsq_pkg::IDX_OTP, ACC, ~d1, 2'h0, 5'h1F, 1'h0, 1'h1);
        chk(otp[p], d1);
        p = (p + 1) % 8;
        run(fsq_pkg::CMD_OTP, 7'h00, 16'(p), fsq_pkg::IDX_OTP, DONE, fsq_pkg::ERASED);
        run(fsq_pkg::CMD_OTP, 7'h00, 16'(p), fsq_pkg::IDX_OTP, DONE, d2);
        chk(otp[p], d2);
        run(fsq_pkg::CMD_OTP, 7'h00, 16'h0008, fsq_pkg::IDX_OTP, ACC, d2);
        run(fsq_pkg::CMD_OTP, 7'h00, 16'((p + 1) % 8), 3'h4, ACC, d2);
        for (p = 0; p < 5; p++)
            run(8'(7 + p), 7'h7C, 16'h0, idx[p], ACC, d1, 2'h0, 5'h1F & ~(5'h01 << p));
        run(8'h0C, 7'h00, 16'h0000, 3'h0, ACC);
        run(fsq_pkg::CMD_ERBLK, 7'h20, 16'h0000, fsq_pkg::IDX_ERBLK, ACC);
        run(fsq_pkg::CMD_ERSEC, 7'h05, 16'h0000, fsq_pkg::IDX_ERSEC, ACC);
        run(fsq_pkg::CMD_ERBLK, fsq_pkg::PF_BLK_LO, 16'h0003, fsq_pkg::IDX_ERBLK, ACC);
        run(fsq_pkg::CMD_ERBLK, fsq_pkg::DF_BLK, 16'h0001, fsq_pkg::IDX_ERBLK, ACC);
        run(fsq_pkg::CMD_ERSEC, fsq_pkg::PF_BLK_LO, 16'h0104, fsq_pkg::IDX_ERSEC, ACC);
        run(fsq_pkg::CMD_ERBLK, fsq_pkg::PF_BLK_LO, 16'h0200, fsq_pkg::IDX_ERBLK, PV, d1, 2'h1);
        run(fsq_pkg::CMD_ERSEC, fsq_pkg::PF_BLK_LO, 16'h0100, fsq_pkg::IDX_ERSEC, PV, d1, 2'h1);
        run(fsq_pkg::CMD_ERALL, 7'h00, 16'h0000, fsq_pkg::IDX_ERALL, PV, d1, 2'h2);
        run(fsq_pkg::CMD_UNSEC, 7'h00, 16'h0000, fsq_pkg::IDX_UNSEC, PV, d1, 2'h1);
        run(fsq_pkg::CMD_ERBLK, fsq_pkg::DF_BLK, 16'h0002, fsq_pkg::IDX_ERBLK, DONE);
        run(fsq_pkg::CMD_ERBLK, 7'h7F, 16'h0008, fsq_pkg::IDX_ERBLK, DONE);
        run(fsq_pkg::CMD_ERSEC, fsq_pkg::PF_BLK_LO, 16'h0108, fsq_pkg::IDX_ERSEC, DONE);
        run(fsq_pkg::CMD_ERSEC, fsq_pkg::PF_BLK_LO, 16'h0108, fsq_pkg::IDX_ERSEC, VER, d1, 2'h0, 5'h1F, 1'h1);
        run(fsq_pkg::CMD_UNSEC, 7'h00, 16'h0000, fsq_pkg::IDX_UNSEC, VER, d1, 2'h0, 5'h1F, 1'h1);
        rd(fsq_pkg::ADDR_SEC, s);
        chk(64'(s), 64'h1);
        run(fsq_pkg::CMD_ERALL, 7'h00, 16'h0000, 3'h1, ACC);
        run(fsq_pkg::CMD_ERALL, 7'h00, 16'h0000, fsq_pkg::IDX_ERALL, DONE);
        rd(fsq_pkg::ADDR_SEC, s);
        chk(64'(s), 64'h0);
        finish_test;
    end
endmodule
